// file: hdl/ccsagc_attack.v
// left agc attack time selection and decision-aligned latch
`timescale 1ns/10ps
`include "ccsagc_consts.vh"

module ccsagc_attack (
   // clock and reset
   input wire pclk,
   input wire presetn,
   // attack fields from the register bank
   input wire attack_sel,
   input wire [1:0] attack_base,
   input wire [2:0] attack_mult,
   // older attack control path
   input wire [10:0] legacy_attack_ms,
   // agc gain decision strobe
   input wire agc_decision,
   // effective attack time in milliseconds
   output reg [10:0] attack_ms_q
);

   reg [3:0] base_ms;
   wire [10:0] own_ms;
   wire [10:0] attack_ms_d;

   // baseline time lookup
   always @* begin
      case (attack_base)
         2'h0: base_ms = `CCSAGC_BASE_MS0;
         2'h1: base_ms = `CCSAGC_BASE_MS1;
         2'h2: base_ms = `CCSAGC_BASE_MS2;
         default: base_ms = `CCSAGC_BASE_MS3;
      endcase
   end

   // power-of-two scaling, worst case 11 ms * 128 fits 11 bits
   assign own_ms = {7'h00, base_ms} << attack_mult;
   assign attack_ms_d = attack_sel ? own_ms : legacy_attack_ms;

   // only sampled at a decision so a gain step already in flight keeps its time
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         attack_ms_q <= `CCSAGC_RST_ATTACK_MS;
      end else if (agc_decision) begin
         attack_ms_q <= attack_ms_d;
      end
   end

endmodule // ccsagc_attack

// file: hdl/ccsagc_consts.vh
// constants for the clock select and left agc attack register bank
`ifndef CCSAGC_CONSTS_VH
`define CCSAGC_CONSTS_VH

// ******************************************
// register indices (byte address = 4 * index)
// ******************************************
`define CCSAGC_IDX_STATUS 10'h060
`define CCSAGC_IDX_RSVD_A 10'h063
`define CCSAGC_IDX_RSVD_B 10'h064
`define CCSAGC_IDX_CLK_SRC 10'h065
`define CCSAGC_IDX_CLK_GEN 10'h066
`define CCSAGC_IDX_ATTACK 10'h067
`define CCSAGC_ADDR_W 12

// ******************************************
// field positions
// ******************************************
`define CCSAGC_CLK_SRC_BIT 0
`define CCSAGC_DIV_SRC_HI 7
`define CCSAGC_DIV_SRC_LO 6
`define CCSAGC_PLL_SRC_HI 5
`define CCSAGC_PLL_SRC_LO 4
`define CCSAGC_PREDIV_HI 3
`define CCSAGC_PREDIV_LO 0
`define CCSAGC_ATK_SEL_BIT 7
`define CCSAGC_ATK_BASE_HI 6
`define CCSAGC_ATK_BASE_LO 5
`define CCSAGC_ATK_MULT_HI 4
`define CCSAGC_ATK_MULT_LO 2
`define CCSAGC_ATK_RSVD_HI 1
`define CCSAGC_ATK_RSVD_LO 0
`define CCSAGC_ST_CODE_BIT 0
`define CCSAGC_ST_RSVD_BIT 1
`define CCSAGC_ST_BUSY_BIT 2

// ******************************************
// reset values and encodings
// ******************************************
`define CCSAGC_RST_CLK_SRC 1'h0
`define CCSAGC_RST_CLK_GEN 8'h02
`define CCSAGC_RST_ATTACK 8'h00
`define CCSAGC_SRC_MCLK 2'h0
`define CCSAGC_SRC_BCLK 2'h2
`define CCSAGC_PREDIV_16 4'h0
`define CCSAGC_PREDIV_17 4'h1
`define CCSAGC_BASE_MS0 4'h7
`define CCSAGC_BASE_MS1 4'h8
`define CCSAGC_BASE_MS2 4'hA
`define CCSAGC_BASE_MS3 4'hB
`define CCSAGC_RST_ATTACK_MS 11'h007

// ******************************************
// timing
// ******************************************
`define CCSAGC_CLK_PERIOD_NS 100
`define CCSAGC_MS_NS 1000000
`define CCSAGC_MS_CYCLES (`CCSAGC_MS_NS / `CCSAGC_CLK_PERIOD_NS)

`endif

// file: hdl/ccsagc_regs.v
// apb register bank for codec clock selection and left agc attack time
//
// Operation
// - d0 picks pll divider or clock divider
// - divider input: master or bit clock
// - pll reference: master or bit clock
// - predivider 0 means 16, 1 means 17
// - d7 picks legacy or own attack time
// - baseline attack 7, 8, 10, 11 ms
// - multiplier scales baseline by two to power
// - reserved registers read zero, never written
// - clock source upper bits read zero
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/10ps
`include "ccsagc_consts.vh"

module ccsagc_regs #(
   parameter MS_CYCLES = `CCSAGC_MS_CYCLES
) (
   // clock and reset
   input wire pclk,
   input wire presetn,
   // apb slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [`CCSAGC_ADDR_W-1:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   // clock pins and divider outputs, sampled as ordinary inputs
   input wire master_clock_pin,
   input wire bit_clock_pin,
   input wire pll_divider_output,
   input wire clock_divider_output,
   // selected clocks towards the clock tree
   output reg codec_core_clock_input,
   output reg clock_divider_input,
   output reg pll_reference_input,
   // pll predivider value, 2 to 17
   output reg [4:0] pll_predivider_n,
   // left agc attack interface
   input wire [10:0] legacy_attack_ms,
   input wire agc_decision,
   output wire [10:0] left_attack_ms,
   output reg left_attack_elapsed
);

   // ******************************************
   // decode helpers
   // ******************************************

   // register index of a word-aligned byte address, all ones if misaligned
   function [9:0] word_index;
      input [`CCSAGC_ADDR_W-1:0] addr;
      begin
         if (addr[1:0] != 2'h0) begin
            word_index = 10'h3FF;
         end else begin
            word_index = addr[`CCSAGC_ADDR_W-1:2];
         end
      end
   endfunction

   // whether an index is one of the mapped registers
   function index_mapped;
      input [9:0] idx;
      begin
         case (idx)
            `CCSAGC_IDX_STATUS: index_mapped = 1'b1;
            `CCSAGC_IDX_RSVD_A: index_mapped = 1'b1;
            `CCSAGC_IDX_RSVD_B: index_mapped = 1'b1;
            `CCSAGC_IDX_CLK_SRC: index_mapped = 1'b1;
            `CCSAGC_IDX_CLK_GEN: index_mapped = 1'b1;
            `CCSAGC_IDX_ATTACK: index_mapped = 1'b1;
            default: index_mapped = 1'b0;
         endcase
      end
   endfunction

   // a two-bit source code picks the bit clock only for code 10
   function pick_bit_clock;
      input [1:0] code;
      begin
         pick_bit_clock = (code == `CCSAGC_SRC_BCLK);
      end
   endfunction

   // a source code that software should never write
   function code_reserved;
      input [1:0] code;
      begin
         code_reserved = (code != `CCSAGC_SRC_MCLK) && (code != `CCSAGC_SRC_BCLK);
      end
   endfunction

   // ******************************************
   // bus decode
   // ******************************************

   wire [9:0] bus_idx;
   wire bus_hit;
   wire acc_phase;
   wire wr_acc;
   wire rd_setup;

   assign bus_idx = word_index(paddr);
   assign bus_hit = index_mapped(bus_idx);
   assign acc_phase = psel & penable;
   assign wr_acc = acc_phase & pwrite & bus_hit;
   assign rd_setup = psel & ~penable & ~pwrite;

   // zero wait states; unmapped or misaligned access answers with an error
   assign pready = 1'b1;
   assign pslverr = acc_phase & ~bus_hit;

   // ******************************************
   // register storage
   // ******************************************

   reg clk_src_q;
   reg [7:0] clk_gen_q;
   reg [7:0] attack_q;
   reg code_err_q;
   reg rsvd_err_q;
   reg code_err_d;
   reg rsvd_err_d;
   reg busy_q;

   // writable fields; reserved registers take no write at all
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_src_q <= `CCSAGC_RST_CLK_SRC;
         clk_gen_q <= `CCSAGC_RST_CLK_GEN;
         attack_q <= `CCSAGC_RST_ATTACK;
      end else if (wr_acc) begin
         case (bus_idx)
            `CCSAGC_IDX_CLK_SRC: clk_src_q <= pwdata[`CCSAGC_CLK_SRC_BIT];
            `CCSAGC_IDX_CLK_GEN: clk_gen_q <= pwdata[7:0];
            `CCSAGC_IDX_ATTACK: attack_q <= pwdata[7:0];
            default: clk_src_q <= clk_src_q;
         endcase
      end
   end

   // ******************************************
   // misuse tracking
   // ******************************************

   // sticky flags for writes that break the software contract;
   // a fresh misuse in the clearing cycle keeps the flag set
   always @* begin
      code_err_d = code_err_q;
      rsvd_err_d = rsvd_err_q;
      if (wr_acc && bus_idx == `CCSAGC_IDX_STATUS) begin
         if (pwdata[`CCSAGC_ST_CODE_BIT]) begin
            code_err_d = 1'b0;
         end
         if (pwdata[`CCSAGC_ST_RSVD_BIT]) begin
            rsvd_err_d = 1'b0;
         end
      end
      if (wr_acc && bus_idx == `CCSAGC_IDX_CLK_GEN) begin
         if (code_reserved(pwdata[`CCSAGC_DIV_SRC_HI:`CCSAGC_DIV_SRC_LO])) begin
            code_err_d = 1'b1;
         end
         if (code_reserved(pwdata[`CCSAGC_PLL_SRC_HI:`CCSAGC_PLL_SRC_LO])) begin
            code_err_d = 1'b1;
         end
      end
      if (wr_acc && (bus_idx == `CCSAGC_IDX_RSVD_A || bus_idx == `CCSAGC_IDX_RSVD_B)) begin
         rsvd_err_d = 1'b1;
      end
      if (wr_acc && bus_idx == `CCSAGC_IDX_CLK_SRC && pwdata[7:1] != 7'h00) begin
         rsvd_err_d = 1'b1;
      end
      if (wr_acc && bus_idx == `CCSAGC_IDX_ATTACK) begin
         if (pwdata[`CCSAGC_ATK_RSVD_HI:`CCSAGC_ATK_RSVD_LO] != 2'h0) begin
            rsvd_err_d = 1'b1;
         end
      end
   end

   // flag flops
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         code_err_q <= 1'b0;
         rsvd_err_q <= 1'b0;
      end else begin
         code_err_q <= code_err_d;
         rsvd_err_q <= rsvd_err_d;
      end
   end

   // ******************************************
   // read path
   // ******************************************

   // read data is captured in the setup cycle so it comes from a flop
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (rd_setup) begin
         case (bus_idx)
            `CCSAGC_IDX_STATUS: prdata <= {29'h00000000, busy_q, rsvd_err_q, code_err_q};
            `CCSAGC_IDX_CLK_SRC: prdata <= {31'h00000000, clk_src_q};
            `CCSAGC_IDX_CLK_GEN: prdata <= {24'h000000, clk_gen_q};
            `CCSAGC_IDX_ATTACK: prdata <= {24'h000000, attack_q};
            default: prdata <= 32'h00000000;
         endcase
      end
   end

   // ******************************************
   // clock source selection
   // ******************************************

   wire div_bclk;
   wire pll_bclk;

   // reserved codes fall back to the master clock so the tree never stops
   assign div_bclk = pick_bit_clock(clk_gen_q[`CCSAGC_DIV_SRC_HI:`CCSAGC_DIV_SRC_LO]);
   assign pll_bclk = pick_bit_clock(clk_gen_q[`CCSAGC_PLL_SRC_HI:`CCSAGC_PLL_SRC_LO]);

   // registered selections; the pins are treated as data at pclk rate
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         codec_core_clock_input <= 1'b0;
         clock_divider_input <= 1'b0;
         pll_reference_input <= 1'b0;
      end else begin
         codec_core_clock_input <= clk_src_q ? clock_divider_output : pll_divider_output;
         clock_divider_input <= div_bclk ? bit_clock_pin : master_clock_pin;
         pll_reference_input <= pll_bclk ? bit_clock_pin : master_clock_pin;
      end
   end

   // ******************************************
   // pll predivider
   // ******************************************

   reg [4:0] prediv_d;

   // codes 0 and 1 stand for 16 and 17, the rest are literal
   always @* begin
      case (clk_gen_q[`CCSAGC_PREDIV_HI:`CCSAGC_PREDIV_LO])
         `CCSAGC_PREDIV_16: prediv_d = 5'h10;
         `CCSAGC_PREDIV_17: prediv_d = 5'h11;
         default: prediv_d = {1'b0, clk_gen_q[`CCSAGC_PREDIV_HI:`CCSAGC_PREDIV_LO]};
      endcase
   end

   // predivider output flop
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pll_predivider_n <= 5'h02;
      end else begin
         pll_predivider_n <= prediv_d;
      end
   end

   // ******************************************
   // left agc attack time
   // ******************************************

   ccsagc_attack u_attack (
      .pclk(pclk),
      .presetn(presetn),
      .attack_sel(attack_q[`CCSAGC_ATK_SEL_BIT]),
      .attack_base(attack_q[`CCSAGC_ATK_BASE_HI:`CCSAGC_ATK_BASE_LO]),
      .attack_mult(attack_q[`CCSAGC_ATK_MULT_HI:`CCSAGC_ATK_MULT_LO]),
      .legacy_attack_ms(legacy_attack_ms),
      .agc_decision(agc_decision),
      .attack_ms_q(left_attack_ms)
   );

   // ******************************************
   // millisecond tick divider
   // ******************************************

   localparam [15:0] MS_LAST = MS_CYCLES[15:0] - 16'h0001;

   reg [15:0] ms_cnt_q;
   reg ms_tick;

   // free-running divider, a one-cycle enable every millisecond
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ms_cnt_q <= 16'h0000;
         ms_tick <= 1'b0;
      end else if (ms_cnt_q == MS_LAST) begin
         ms_cnt_q <= 16'h0000;
         ms_tick <= 1'b1;
      end else begin
         ms_cnt_q <= ms_cnt_q + 16'h0001;
         ms_tick <= 1'b0;
      end
   end

   // ******************************************
   // attack window timer
   // ******************************************

   localparam [2:0] ST_IDLE = 3'b001;
   localparam [2:0] ST_ARM = 3'b010;
   localparam [2:0] ST_RUN = 3'b100;

   reg [2:0] state_q;
   reg [2:0] state_d;
   reg [10:0] win_cnt_q;
   reg [10:0] win_cnt_d;
   reg elapsed_d;

   // a decision restarts the window; the arm cycle lets the attack latch
   // settle so the window always uses the time taken at that decision
   always @* begin
      state_d = state_q;
      win_cnt_d = win_cnt_q;
      elapsed_d = 1'b0;
      case (state_q)
         ST_IDLE: begin
            if (agc_decision) begin
               state_d = ST_ARM;
            end
         end
         ST_ARM: begin
            win_cnt_d = 11'h000;
            state_d = agc_decision ? ST_ARM : ST_RUN;
         end
         ST_RUN: begin
            if (agc_decision) begin
               state_d = ST_ARM;
            end else if (ms_tick) begin
               if (win_cnt_q + 11'h001 >= left_attack_ms) begin
                  elapsed_d = 1'b1;
                  state_d = ST_IDLE;
               end else begin
                  win_cnt_d = win_cnt_q + 11'h001;
               end
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   // timer flops; busy is visible in the status register
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= ST_IDLE;
         win_cnt_q <= 11'h000;
         left_attack_elapsed <= 1'b0;
         busy_q <= 1'b0;
      end else begin
         state_q <= state_d;
         win_cnt_q <= win_cnt_d;
         left_attack_elapsed <= elapsed_d;
         busy_q <= (state_d != ST_IDLE);
      end
   end

endmodule // ccsagc_regs

// file: sim/ccsagc_regs_assertions.sv
// assertion checker for the clock select and attack register bank
`timescale 1ns/10ps
module ccsagc_regs_chk #(
   parameter MS_CYCLES = 10
) (
   // clock and reset
   input logic pclk,
   input logic presetn,
   // apb slave
   input logic psel,
   input logic penable,
   input logic pwrite,
   input logic [11:0] paddr,
   input logic [31:0] pwdata,
   input logic [31:0] prdata,
   input logic pready,
   input logic pslverr,
   // clock pins and selected clocks
   input logic master_clock_pin,
   input logic bit_clock_pin,
   input logic pll_divider_output,
   input logic clock_divider_output,
   input logic codec_core_clock_input,
   input logic clock_divider_input,
   input logic pll_reference_input,
   input logic [4:0] pll_predivider_n,
   // attack
   input logic [10:0] legacy_attack_ms,
   input logic agc_decision,
   input logic [10:0] left_attack_ms
);
   logic src_q;
   logic [7:0] gen_q;
   logic [7:0] atk_q;
   logic [31:0] rd_exp;
   logic rd_map;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // shadow of the writable fields, so reads and routing can be judged
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         src_q <= 1'h0;
         gen_q <= 8'h02;
         atk_q <= 8'h00;
      end else if (psel && penable && pwrite && pready) begin
         if (paddr == 12'h194) src_q <= pwdata[0];
         if (paddr == 12'h198) gen_q <= pwdata[7:0];
         if (paddr == 12'h19C) atk_q <= pwdata[7:0];
      end
   end

   // expected read word; status is left out since its busy bit is timer driven
   always_comb begin
      rd_map = 1'h1;
      case (paddr)
         12'h18C, 12'h190: rd_exp = 32'h0;
         12'h194: rd_exp = {31'h0, src_q};
         12'h198: rd_exp = {24'h0, gen_q};
         12'h19C: rd_exp = {24'h0, atk_q};
         default: begin
            rd_exp = 32'h0;
            rd_map = 1'h0;
         end
      endcase
   end

   function automatic logic [10:0] atk_ms(input logic [7:0] a);
      logic [10:0] b;
      b = (a[6:5] == 2'h0) ? 11'h007 : (a[6:5] == 2'h1) ? 11'h008 : (a[6:5] == 2'h2) ? 11'h00A : 11'h00B;
      return b << a[4:2];
   endfunction

   // ****************
   // assertions
   // ****************
   a_core_clk_route: assert property ($past(presetn) |->
      codec_core_clock_input == $past(src_q ? clock_divider_output : pll_divider_output))
      else $error("core clock input not from selected divider");
   a_div_src_route: assert property ($past(presetn) |->
      clock_divider_input == $past(gen_q[7:6] == 2'h2 ? bit_clock_pin : master_clock_pin))
      else $error("divider input not from selected pin");
   a_pll_src_route: assert property ($past(presetn) |->
      pll_reference_input == $past(gen_q[5:4] == 2'h2 ? bit_clock_pin : master_clock_pin))
      else $error("pll reference not from selected pin");
   a_prediv_decode: assert property ($past(presetn) && $stable(gen_q) |-> pll_predivider_n ==
      ((gen_q[3:0] == 4'h0) ? 5'h10 : (gen_q[3:0] == 4'h1) ? 5'h11 : {1'h0, gen_q[3:0]}))
      else $error("predivider value wrongly decoded");
   a_attack_load: assert property (agc_decision |=>
      left_attack_ms == $past(atk_q[7] ? atk_ms(atk_q) : legacy_attack_ms))
      else $error("attack time wrong after decision");
   a_attack_hold: assert property (!agc_decision |=> $stable(left_attack_ms))
      else $error("attack time changed without decision");
   a_read_back: assert property (psel && !penable && !pwrite && rd_map |=>
      prdata == $past(rd_exp))
      else $error("read data differs from register contents");
   a_mapped_ok: assert property (psel && penable && rd_map |-> pready && !pslverr)
      else $error("mapped access not completed cleanly");

   // main scenarios reached
   c_attack_own: cover property (agc_decision && atk_q[7]);
   c_rsvd_read: cover property (psel && !penable && !pwrite && paddr == 12'h18C);
   c_bclk_both: cover property (gen_q[7:6] == 2'h2 && gen_q[5:4] == 2'h2);
endmodule // ccsagc_regs_chk

bind ccsagc_regs ccsagc_regs_chk #(.MS_CYCLES(MS_CYCLES)) u_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .master_clock_pin(master_clock_pin), .bit_clock_pin(bit_clock_pin),
   .pll_divider_output(pll_divider_output), .clock_divider_output(clock_divider_output),
   .codec_core_clock_input(codec_core_clock_input), .clock_divider_input(clock_divider_input),
   .pll_reference_input(pll_reference_input), .pll_predivider_n(pll_predivider_n),
   .legacy_attack_ms(legacy_attack_ms), .agc_decision(agc_decision), .left_attack_ms(left_attack_ms));

// file: sim/ccsagc_regs_tb_top.sv
// self-checking testbench for the clock select and attack register bank
`timescale 1ns/10ps
`include "ccsagc_consts.vh"
module ccsagc_regs_tb_top;
   localparam logic [11:0] A_ST = {`CCSAGC_IDX_STATUS, 2'h0};
   localparam logic [11:0] A_RA = {`CCSAGC_IDX_RSVD_A, 2'h0};
   localparam logic [11:0] A_RB = {`CCSAGC_IDX_RSVD_B, 2'h0};
   localparam logic [11:0] A_SRC = {`CCSAGC_IDX_CLK_SRC, 2'h0};
   localparam logic [11:0] A_GEN = {`CCSAGC_IDX_CLK_GEN, 2'h0};
   localparam logic [11:0] A_ATK = {`CCSAGC_IDX_ATTACK, 2'h0};
   logic pclk;
   logic presetn;
   logic psel;
   logic penable;
   logic pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [2:0] cnt_q;
   logic codec_core_clock_input;
   logic clock_divider_input;
   logic pll_reference_input;
   logic [4:0] pll_predivider_n;
   logic [10:0] legacy_attack_ms;
   logic agc_decision;
   logic [10:0] left_attack_ms;
   logic left_attack_elapsed;
   logic [31:0] rd_q;
   logic err_q;
   int n_mismatch = 0;
   int n_tests = 0;
   int cyc = 0;

   ccsagc_regs #(.MS_CYCLES(10)) uut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .master_clock_pin(cnt_q[0]), .bit_clock_pin(cnt_q[1]),
      .pll_divider_output(cnt_q[2]), .clock_divider_output(^cnt_q),
      .codec_core_clock_input(codec_core_clock_input), .clock_divider_input(clock_divider_input),
      .pll_reference_input(pll_reference_input), .pll_predivider_n(pll_predivider_n),
      .legacy_attack_ms(legacy_attack_ms), .agc_decision(agc_decision),
      .left_attack_ms(left_attack_ms), .left_attack_elapsed(left_attack_elapsed));

   initial begin
      pclk = 1'h0;
      forever #50 pclk = ~pclk;
   end

   // distinct pin patterns so a wrong route shows up
   always @(posedge pclk) begin
      cnt_q <= cnt_q + 3'h1;
   end

   // a hang is cut short well above the expected run length
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_mismatch++;
         give_verdict;
      end
   end

   // ****************
   // bus and compare tasks
   // ****************
   task automatic apb(input logic [11:0] a, input logic [31:0] d, input logic w);
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1);
      rd_q = prdata;
      err_q = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
      apb(a, 32'h0, 1'h0);
      chk(nm, e, rd_q);
   endtask

   // one cycle decision strobe, result settled when this returns
   task automatic decide;
      @(posedge pclk);
      agc_decision <= 1'h1;
      @(posedge pclk);
      agc_decision <= 1'h0;
      @(posedge pclk);
   endtask

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // ****************
   // scenarios
   // ****************
   task automatic t_reset;
      rdc("rsvd_a", A_RA, 32'h0);
      rdc("rsvd_b", A_RB, 32'h0);
      rdc("clk_src", A_SRC, 32'h0);
      rdc("clk_gen", A_GEN, 32'h02);
      rdc("attack", A_ATK, 32'h0);
      chk("prediv", 32'h2, pll_predivider_n);
      $display("done reset values");
   endtask

   task automatic t_clk;
      logic [7:0] v;
      for (int i = 0; i < 16; i++) begin
         v = {i[0] ? 2'h2 : 2'h0, i[1] ? 2'h2 : 2'h0, i[3:0]};
         apb(A_GEN, {24'h0, v}, 1'h1);
         rdc("clk_gen", A_GEN, {24'h0, v});
         chk("prediv", (i < 2) ? i + 16 : i, pll_predivider_n);
         apb(A_SRC, {31'h0, i[0]}, 1'h1);
         rdc("clk_src", A_SRC, {31'h0, i[0]});
      end
      $display("done clock selection");
   endtask

   // refused accesses: reserved places stay zero, unmapped flags an error
   task automatic t_rsvd;
      apb(A_RA, 32'hFF, 1'h1);
      apb(A_RB, 32'hFF, 1'h1);
      rdc("rsvd_a", A_RA, 32'h0);
      rdc("rsvd_b", A_RB, 32'h0);
      apb(A_SRC, 32'hFF, 1'h1);
      rdc("clk_src_upper", A_SRC, 32'h1);
      apb(12'h1A0, 32'hFF, 1'h1);
      chk("unmapped_err", 32'h1, err_q);
      rdc("status_rsvd", A_ST, 32'h2);
      apb(A_ST, 32'h3, 1'h1);
      rdc("status_clear", A_ST, 32'h0);
      $display("done reserved access");
   endtask

   task automatic t_attack;
      logic [10:0] base [4];
      logic [10:0] ms;
      base = '{11'h007, 11'h008, 11'h00A, 11'h00B};
      ms = 11'h007;
      legacy_attack_ms <= 11'h123;
      for (int b = 0; b < 4; b++) begin
         for (int m = 0; m < 8; m++) begin
            apb(A_ATK, {24'h0, 1'h1, b[1:0], m[2:0], 2'h0}, 1'h1);
            chk("attack_hold", ms, left_attack_ms);
            decide;
            ms = base[b] << m;
            chk("attack_ms", ms, left_attack_ms);
         end
      end
      apb(A_ATK, 32'h0, 1'h1);
      decide;
      chk("attack_legacy", 32'h123, left_attack_ms);
      $display("done attack time");
   endtask

   // 7 ms window of 10-cycle ticks; the free tick phase gives a 10-cycle spread
   task automatic t_timer;
      int n;
      apb(A_ATK, 32'h80, 1'h1);
      decide;
      rdc("status_busy", A_ST, 32'h4);
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (left_attack_elapsed !== 1'h1 && n < 200);
      chk("attack_window", 32'h1, (n >= 59 && n <= 68));
      rdc("status_idle", A_ST, 32'h0);
      $display("done attack window");
   endtask

   initial begin
      presetn = 1'h0;
      psel = 1'h0;
      penable = 1'h0;
      pwrite = 1'h0;
      paddr = 12'h0;
      pwdata = 32'h0;
      cnt_q = 3'h0;
      legacy_attack_ms = 11'h0;
      agc_decision = 1'h0;
      repeat (12) @(posedge pclk);
      presetn <= 1'h1;
      t_reset;
      t_clk;
      t_rsvd;
      t_attack;
      t_timer;
      give_verdict;
   end
endmodule // ccsagc_regs_tb_top
